//--- rtl/reset_source_pkg.sv
// constants and types shared by the reset source controller
package reset_source_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] RESET_SOURCE_FLAGS_ADDR = 8'hef;
  localparam int PIN_BIT = 0;
  localparam int POR_BIT = 1;
  localparam int MCD_BIT = 2;
  localparam int WDT_BIT = 3;
  localparam int SW_BIT = 4;
  localparam int COMP_BIT = 5;
  localparam int FLASH_BIT = 6;
  localparam int CAUSE_WIDTH = 7;
  localparam logic [CAUSE_WIDTH-1:0] CAUSE_AFTER_POR = 7'h02;
  localparam logic [CAUSE_WIDTH-1:0] CAUSE_NONE = 7'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [15:0] FLASH_RESERVED_BASE_DEFAULT = 16'hfc00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_HOLD_NS = 100;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDT_CLOCK_DIVIDE = 12;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HOLD = 2'b01,
    ST_PIN_WAIT = 2'b11
  } seq_state_type;
  typedef struct packed {
    logic program_write_enable;
    logic xmove_write;
    logic code_read;
    logic fetch;
    logic op_read;
    logic op_write;
    logic op_erase;
    logic security_block;
    logic [15:0] addr;
  } flash_access_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_bus_type;
endpackage

//--- rtl/reset_source_controller.sv
// reset source controller: gathers reset requests, holds system reset, records the cause
`timescale 1ns/100ps
module reset_source_controller #(
  parameter logic [15:0] FLASH_RESERVED_BASE = reset_source_pkg::FLASH_RESERVED_BASE_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire reset_source_pkg::sfr_bus_type sfr,
  output logic [7:0] sfr_rdata,
  input wire reset_source_pkg::flash_access_type flash,
  input wire logic supply_high_threshold,
  input wire logic comparator_out,
  input wire logic supply_low,
  input wire logic mcd_timeout,
  input wire logic rst_pin_n,
  input wire logic watchdog_overflow,
  input wire logic watchdog_disable,
  output logic system_reset,
  output logic watchdog_enable,
  output logic watchdog_tick,
  output logic missing_clock_enable
);
  import reset_source_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic above_reserved(input logic [15:0] addr);
    above_reserved = (addr >= FLASH_RESERVED_BASE);
  endfunction

  // one cause wins when several arrive together; the pin and supply come first
  function automatic logic [CAUSE_WIDTH-1:0] pick_cause(input logic [CAUSE_WIDTH-1:0] req);
    pick_cause = CAUSE_NONE;
    if (req[PIN_BIT]) begin
      pick_cause[PIN_BIT] = 1'b1;
    end else if (req[POR_BIT]) begin
      pick_cause[POR_BIT] = 1'b1;
    end else if (req[MCD_BIT]) begin
      pick_cause[MCD_BIT] = 1'b1;
    end else if (req[FLASH_BIT]) begin
      pick_cause[FLASH_BIT] = 1'b1;
    end else if (req[WDT_BIT]) begin
      pick_cause[WDT_BIT] = 1'b1;
    end else if (req[COMP_BIT]) begin
      pick_cause[COMP_BIT] = 1'b1;
    end else if (req[SW_BIT]) begin
      pick_cause[SW_BIT] = 1'b1;
    end
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic comp_sync;
  logic supply_low_sync;
  logic mcd_sync;
  logic pin_n_sync;

  // pin and comparator idle high so a power-on does not look like a request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 4'h9;
      sync2_reg <= 4'h9;
    end else begin
      sync1_reg <= {rst_pin_n, mcd_timeout, supply_low, comparator_out};
      sync2_reg <= sync1_reg;
    end
  end

  assign comp_sync = sync2_reg[0];
  assign supply_low_sync = sync2_reg[1];
  assign mcd_sync = sync2_reg[2];
  assign pin_n_sync = sync2_reg[3];

  // ----------------------------------------
  // register state
  // ----------------------------------------
  seq_state_type state_reg;
  seq_state_type state_next;
  logic [CAUSE_WIDTH-1:0] cause_reg;
  logic [CAUSE_WIDTH-1:0] pending_reg;
  logic [CAUSE_WIDTH-1:0] req_now;
  logic [7:0] hold_count_reg;
  logic comp_en_reg;
  logic mcd_en_reg;
  logic vdd_en_reg;
  logic system_reset_reg;
  logic wdt_en_reg;
  logic wdt_tick_reg;
  logic [3:0] wdt_div_reg;
  logic [7:0] sfr_rdata_reg;
  logic reg_write;
  logic flash_any_op;
  logic flash_err;
  logic enter_reset;

  assign reg_write = sfr.wr && (sfr.addr == RESET_SOURCE_FLAGS_ADDR) && (state_reg == ST_RUN);
  assign flash_any_op = flash.op_read || flash.op_write || flash.op_erase;

  // ----------------------------------------
  // reset requests
  // ----------------------------------------
  always_comb begin
    flash_err = 1'b0;
    if (flash.program_write_enable && flash.xmove_write && above_reserved(flash.addr)) begin
      flash_err = 1'b1;
    end
    if (flash.code_read && above_reserved(flash.addr)) begin
      flash_err = 1'b1;
    end
    if (flash.fetch && above_reserved(flash.addr)) begin
      flash_err = 1'b1;
    end
    if (flash_any_op && flash.security_block) begin
      flash_err = 1'b1;
    end
    if (flash_any_op && !(supply_high_threshold && vdd_en_reg)) begin
      flash_err = 1'b1;
    end
  end

  always_comb begin
    req_now = CAUSE_NONE;
    req_now[PIN_BIT] = !pin_n_sync;
    req_now[POR_BIT] = supply_low_sync && vdd_en_reg;
    req_now[MCD_BIT] = mcd_sync && mcd_en_reg;
    req_now[WDT_BIT] = watchdog_overflow && wdt_en_reg;
    req_now[SW_BIT] = reg_write && sfr.wdata[SW_BIT];
    req_now[COMP_BIT] = comp_en_reg && !comp_sync;
    req_now[FLASH_BIT] = flash_err;
  end

  // a request that arrives while a reset is already under way is dropped on purpose:
  // the reset it asks for is happening anyway
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= CAUSE_NONE;
    end else if (state_reg != ST_RUN || enter_reset) begin
      pending_reg <= CAUSE_NONE;
    end else begin
      pending_reg <= pending_reg | req_now;
    end
  end

  // ----------------------------------------
  // reset sequencer
  // ----------------------------------------
  assign enter_reset = (state_reg == ST_RUN) && (pending_reg != CAUSE_NONE);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (enter_reset) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (hold_count_reg == 8'h00) begin
          state_next = pin_n_sync ? ST_RUN : ST_PIN_WAIT;
        end
      end
      ST_PIN_WAIT: begin
        if (pin_n_sync) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
  end

  // power-on starts in the hold state so the whole chip sees one clean reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_HOLD;
      system_reset_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      system_reset_reg <= (state_next != ST_RUN);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_count_reg <= 8'(RESET_HOLD_CYCLES - 1);
    end else if (state_reg == ST_RUN) begin
      hold_count_reg <= 8'(RESET_HOLD_CYCLES - 1);
    end else if (state_reg == ST_HOLD && hold_count_reg != 8'h00) begin
      hold_count_reg <= hold_count_reg - 8'h01;
    end
  end

  // the flag names one cause; reads during reset are not possible so recording
  // the pin at entry shows the same value as recording it at exit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= CAUSE_AFTER_POR;
    end else if (enter_reset) begin
      cause_reg <= pick_cause(pending_reg);
    end
  end

  // ----------------------------------------
  // enables written by software
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_en_reg <= 1'b0;
      mcd_en_reg <= 1'b0;
      vdd_en_reg <= 1'b1;
    end else if (enter_reset) begin
      comp_en_reg <= 1'b0;
      mcd_en_reg <= 1'b0;
    end else if (reg_write) begin
      comp_en_reg <= sfr.wdata[COMP_BIT];
      mcd_en_reg <= sfr.wdata[MCD_BIT];
      vdd_en_reg <= sfr.wdata[POR_BIT];
    end
  end

  // ----------------------------------------
  // watchdog enable and divided clock
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_en_reg <= 1'b1;
    end else if (system_reset_reg) begin
      wdt_en_reg <= 1'b1;
    end else if (watchdog_disable) begin
      wdt_en_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_div_reg <= 4'h0;
      wdt_tick_reg <= 1'b0;
    end else if (system_reset_reg) begin
      wdt_div_reg <= 4'h0;
      wdt_tick_reg <= 1'b0;
    end else if (wdt_div_reg == 4'(WDT_CLOCK_DIVIDE - 1)) begin
      wdt_div_reg <= 4'h0;
      wdt_tick_reg <= 1'b1;
    end else begin
      wdt_div_reg <= wdt_div_reg + 4'h1;
      wdt_tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_reg <= READ_UNMAPPED;
    end else if (sfr.rd) begin
      if (sfr.addr == RESET_SOURCE_FLAGS_ADDR) begin
        sfr_rdata_reg <= {1'b0, cause_reg};
      end else begin
        sfr_rdata_reg <= READ_UNMAPPED;
      end
    end
  end

  // no output reaches the reset pin: internal causes leave it alone
  assign system_reset = system_reset_reg;
  assign sfr_rdata = sfr_rdata_reg;
  assign watchdog_enable = wdt_en_reg;
  assign watchdog_tick = wdt_tick_reg;
  assign missing_clock_enable = mcd_en_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_comp_reset_entry: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_RUN && comp_en_reg && !comp_sync) |-> ##[1:2] system_reset_reg)
    else $error("comparator low did not start a reset");
  a_comp_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_write && !enter_reset) |=> (comp_en_reg == $past(sfr.wdata[COMP_BIT])))
    else $error("comparator enable not taken from write");
  a_one_cause_flag: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot(cause_reg))
    else $error("cause flags not one-hot");
  a_wdt_reset: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_RUN && !enter_reset && watchdog_overflow && wdt_en_reg)
    |-> ##2 (system_reset_reg && pending_reg == CAUSE_NONE))
    else $error("watchdog overflow did not reset");
  a_flash_write_err: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_RUN && !enter_reset && flash.program_write_enable && flash.xmove_write
     && flash.addr >= FLASH_RESERVED_BASE) |=> pending_reg[FLASH_BIT])
    else $error("reserved flash write not latched");
  a_sw_force: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_write && !enter_reset && sfr.wdata[SW_BIT]) |-> ##2 (system_reset_reg && state_reg == ST_HOLD))
    else $error("software force did not reset");
  a_bit7_zero: assert property (@(posedge clk) disable iff (!rst_n)
    $past(sfr.rd) |-> (sfr_rdata_reg[7] == 1'b0))
    else $error("unused bit reads nonzero");
  a_wdt_after_reset: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(system_reset_reg) |-> (wdt_en_reg ##12 (system_reset_reg || (wdt_tick_reg && !$past(wdt_tick_reg)))))
    else $error("watchdog not enabled or divider not twelve");
  a_request_held: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_RUN && pending_reg != CAUSE_NONE) |=> (state_reg == ST_HOLD && system_reset_reg))
    else $error("latched request lost");
  a_mcd_disable: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_write && !enter_reset && !sfr.wdata[MCD_BIT]) |=> !missing_clock_enable)
    else $error("missing clock detector not disabled");
  a_pin_wait: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_PIN_WAIT && !pin_n_sync) |=> system_reset_reg)
    else $error("reset released while pin low");
endmodule

//--- testbench/source_model.sv
// far-side model: comparator, supply monitor, clock detector, reset pin, watchdog, flash controller
`timescale 1ns/100ps
module source_model (
  input wire logic clk,
  input wire logic [3:0] kind,
  input wire logic fire,
  output reset_source_pkg::flash_access_type flash,
  output logic supply_high_threshold,
  output logic comparator_out,
  output logic supply_low,
  output logic mcd_timeout,
  output logic rst_pin_n,
  output logic watchdog_overflow
);
  import reset_source_pkg::*;
  // ----------------------------------------
  // request pulse, four cycles so the 2ff synchronisers see it;
  // kind d keeps the pin low past the hold time to reach the pin wait
  // ----------------------------------------
  logic [4:0] hold_reg = 5'h00;
  logic [3:0] kind_reg = 4'h0;
  logic act;
  assign act = hold_reg != 5'h00;
  always @(posedge clk) begin
    if (fire) begin
      hold_reg <= (kind == 4'hd) ? 5'h14 : 5'h04;
      kind_reg <= kind;
    end else if (act) begin
      hold_reg <= hold_reg - 5'h01;
    end
  end
  always_comb begin
    flash = '0;
    supply_high_threshold = 1'b1;
    comparator_out = !(act && kind_reg == 4'h7);
    supply_low = act && kind_reg == 4'h8;
    mcd_timeout = act && kind_reg == 4'h9;
    rst_pin_n = !(act && (kind_reg == 4'ha || kind_reg == 4'hd));
    watchdog_overflow = act && kind_reg == 4'hb;
    if (act) begin
      case (kind_reg)
        4'h1: flash = '{program_write_enable: 1'b1, xmove_write: 1'b1, addr: 16'hfc00, default: 1'b0};
        4'h2: flash = '{code_read: 1'b1, addr: 16'hffff, default: 1'b0};
        4'h3: flash = '{fetch: 1'b1, addr: 16'hfc00, default: 1'b0};
        4'h4: flash = '{security_block: 1'b1, op_erase: 1'b1, addr: 16'h0000, default: 1'b0};
        4'h5: flash.op_read = 1'b1;
        4'h6: begin
          flash.op_read = 1'b1;
          supply_high_threshold = 1'b0;
        end
        4'hc: flash = '{program_write_enable: 1'b1, xmove_write: 1'b1, addr: 16'hfbff, default: 1'b0};
        default: ;
      endcase
    end
  end
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the reset source controller
`timescale 1ns/100ps
module tb_top;
  import reset_source_pkg::*;
  logic clk, rst_n, fire, wd_off, sup_hi, comp, sup_low, missing_clock_detector, pin_n, wd_ovf, sys_rst, wd_en, wd_tick, mcd_en;
  logic [3:0] kind;
  logic [7:0] rdata;
  logic [7:0] d;
  sfr_bus_type sfr;
  flash_access_type flash;
  int failures;
  int cmp_count;
  int hold_n;
  reset_source_controller dut (.clk(clk), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(rdata), .flash(flash),
    .supply_high_threshold(sup_hi), .comparator_out(comp), .supply_low(sup_low), .mcd_timeout(missing_clock_detector),
    .rst_pin_n(pin_n), .watchdog_overflow(wd_ovf), .watchdog_disable(wd_off), .system_reset(sys_rst),
    .watchdog_enable(wd_en), .watchdog_tick(wd_tick), .missing_clock_enable(mcd_en));
  source_model far (.clk(clk), .kind(kind), .fire(fire), .flash(flash), .supply_high_threshold(sup_hi),
    .comparator_out(comp), .supply_low(sup_low), .mcd_timeout(missing_clock_detector), .rst_pin_n(pin_n),
    .watchdog_overflow(wd_ovf));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task sfr_write(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge clk);
    sfr.wr = 1'b0;
  endtask
  task sfr_read(input logic [7:0] a);
    @(negedge clk);
    sfr.rd = 1'b1;
    sfr.addr = a;
    @(negedge clk);
    sfr.rd = 1'b0;
    d = rdata;
  endtask
  task fire_src(input logic [3:0] k);
    @(negedge clk);
    kind = k;
    fire = 1'b1;
    @(negedge clk);
    fire = 1'b0;
  endtask
  // bounded waits: a request that never resets the chip shows up as an entry mismatch
  task rst_cycle;
    hold_n = 0;
    while (sys_rst !== 1'b1 && hold_n < 20) begin
      @(negedge clk);
      hold_n++;
    end
    check("reset entry", {7'h0, sys_rst}, 8'h01);
    hold_n = 0;
    while (sys_rst === 1'b1 && hold_n < 60) begin
      @(negedge clk);
      hold_n++;
    end
    check("reset exit", {7'h0, sys_rst}, 8'h00);
  endtask
  task cause(input logic [7:0] e);
    rst_cycle();
    sfr_read(RESET_SOURCE_FLAGS_ADDR);
    check("cause", d, e);
  endtask
  task quiet;
    repeat (10) @(negedge clk);
    check("no reset", {7'h0, sys_rst}, 8'h00);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_por;
    cause(8'h02);
    check("wd enable", {7'h0, wd_en}, 8'h01);
  endtask
  task t_soft;
    sfr_write(RESET_SOURCE_FLAGS_ADDR, 8'h12);
    rst_cycle();
    check("hold", 8'(hold_n), 8'(RESET_HOLD_CYCLES));
    sfr_read(RESET_SOURCE_FLAGS_ADDR);
    check("cause", d, 8'h10);
  endtask
  task t_watchdog;
    int n;
    @(negedge clk);
    wd_off = 1'b1;
    @(negedge clk);
    wd_off = 1'b0;
    @(negedge clk);
    check("wd off", {7'h0, wd_en}, 8'h00);
    sfr_write(RESET_SOURCE_FLAGS_ADDR, 8'h12);
    cause(8'h10);
    check("wd on", {7'h0, wd_en}, 8'h01);
    n = 0;
    while (wd_tick !== 1'b1 && n < 30) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (wd_tick !== 1'b1 && n < 30);
    check("tick gap", 8'(n), 8'(WDT_CLOCK_DIVIDE));
    fire_src(4'hb);
    cause(8'h08);
  endtask
  task t_comp;
    fire_src(4'h7);
    quiet();
    sfr_write(RESET_SOURCE_FLAGS_ADDR, 8'h22);
    fire_src(4'h7);
    cause(8'h20);
  endtask
  task t_mcd;
    sfr_write(RESET_SOURCE_FLAGS_ADDR, 8'h06);
    @(negedge clk);
    check("mcd on", {7'h0, mcd_en}, 8'h01);
    sfr_write(RESET_SOURCE_FLAGS_ADDR, 8'h02);
    @(negedge clk);
    check("mcd off", {7'h0, mcd_en}, 8'h00);
    fire_src(4'h9);
    quiet();
    sfr_write(RESET_SOURCE_FLAGS_ADDR, 8'h06);
    fire_src(4'h9);
    cause(8'h04);
  endtask
  task t_flash;
    fire_src(4'hc);
    quiet();
    for (int k = 1; k <= 4; k++) begin
      fire_src(4'(k));
      cause(8'h40);
    end
    fire_src(4'h6);
    cause(8'h40);
    sfr_write(RESET_SOURCE_FLAGS_ADDR, 8'h00);
    fire_src(4'h5);
    cause(8'h40);
  endtask
  task t_pin;
    fire_src(4'ha);
    cause(8'h01);
    fire_src(4'hd);
    cause(8'h01);
    check("pin hold", {7'h0, hold_n > RESET_HOLD_CYCLES}, 8'h01);
    sfr_write(RESET_SOURCE_FLAGS_ADDR, 8'hc9);
    quiet();
    sfr_read(RESET_SOURCE_FLAGS_ADDR);
    check("ro bits", d, 8'h01);
    sfr_read(8'hee);
    check("unmapped", d, READ_UNMAPPED);
  endtask
  task t_monitor;
    fire_src(4'h8);
    quiet();
    sfr_write(RESET_SOURCE_FLAGS_ADDR, 8'h02);
    fire_src(4'h8);
    cause(8'h02);
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    fire = 1'b0;
    kind = 4'h0;
    wd_off = 1'b0;
    sfr = '0;
    failures = 0;
    cmp_count = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    t_por();
    t_soft();
    t_watchdog();
    t_comp();
    t_mcd();
    t_flash();
    t_pin();
    t_monitor();
    end_of_test();
  end
endmodule
